// ### pkg/icd_pkg.sv
/*
 * Constants and types for the instruction cycle decoder.
 * Assumes a core clock where four clock edges make one instruction cycle.
 */
`default_nettype none
package icd_pkg;
    // ==========================================================
    // Word layout
    localparam int WORD_W = 14;
    localparam int FILE_W = 7;
    localparam int FILE_LSB = 0;
    localparam int DEST_BIT = 7;
    localparam int BITNUM_LSB = 7;
    localparam int BITNUM_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int LIT9_W = 9;
    localparam int PTR_BIT = 2;
    localparam int PTR_OFS_BIT = 6;
    localparam int STEP_W = 2;
    // ==========================================================
    // Timing
    localparam int OSC_PER_ICYC = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] CYC_MAX = 2'h3;
    // ==========================================================
    // Register file addresses of the indirect access ports, and the highest file address
    localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
    localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
    localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;

    typedef enum logic [1:0] {
        CLASS_BYTE,
        CLASS_BIT,
        CLASS_LITCTL
    } op_class_t;

    typedef enum logic [1:0] {
        STEP_PRE_INC,
        STEP_PRE_DEC,
        STEP_POST_INC,
        STEP_POST_DEC
    } pointer_step_mode_t;
endpackage : icd_pkg
`default_nettype wire

// ### pkg/dec_if.sv
/*
 * Carrier of decoded fields between the field splitter and the sequencer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface dec_if;
    import icd_pkg::*;
    op_class_t op_class;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_num;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic ptr_num;
    pointer_step_mode_t step_mode;
    logic uses_file;
    logic indirect_ref;
    logic always_two;
    logic cond_skip;
    logic skip_on_bit_set;
    logic dec_skip;
    logic inc_skip;
    modport src (output op_class, file_addr, dest_file, bit_num, lit8, lit11, ptr_num,
        step_mode, uses_file, indirect_ref, always_two, cond_skip, skip_on_bit_set,
        dec_skip, inc_skip);
    modport dst (input op_class, file_addr, dest_file, bit_num, lit8, lit11, ptr_num,
        step_mode, uses_file, indirect_ref, always_two, cond_skip, skip_on_bit_set,
        dec_skip, inc_skip);
endinterface : dec_if
`default_nettype wire

// ### logic/field_split.sv
/*
 * Combinational split of one instruction word into fields and cycle hints.
 * Assumes the word is stable while it is decoded.
 */
`timescale 1ns/10ps
`default_nettype none
module field_split (
    // Word
    input wire logic [13:0] word_in,
    // Fields
    dec_if.src d
);
    import icd_pkg::*;
    logic [13:0] w;
    logic port_sel;
    logic ptr_move;
    logic ptr_indexed;

    assign w = word_in;

    // ==========================================================
    // Fields
    always_comb begin
        d.file_addr = w[FILE_LSB +: FILE_W];
        d.dest_file = w[DEST_BIT];
        d.bit_num = w[BITNUM_LSB +: BITNUM_W];
        d.lit8 = w[LIT8_W-1:0];
        d.lit11 = w[LIT11_W-1:0];
        ptr_move = (w[13:4] == 10'h001);
        ptr_indexed = (w[13:7] == 7'h7e) || (w[13:7] == 7'h7f);
        d.ptr_num = ptr_indexed ? w[PTR_OFS_BIT] : w[PTR_BIT];
        d.step_mode = pointer_step_mode_t'(w[STEP_W-1:0]);
        // Byte class is 00 with nonzero bits 11:8 or 0x0080 to 0x00ff, plus five 11 groups; bit class 01; the rest literal or control.
        if (w[13:12] == 2'h1) begin
            d.op_class = CLASS_BIT;
        end else if (w[13:12] == 2'h0 && w[11:8] != 4'h0) begin
            d.op_class = CLASS_BYTE;
        end else if (w[13:7] == 7'h01) begin
            d.op_class = CLASS_BYTE;
        end else if (w[13:12] == 2'h3 && (w[11:8] == 4'hd || w[11:8] == 4'h7 ||
                     w[11:8] == 4'h5 || w[11:8] == 4'h6 || w[11:8] == 4'hb)) begin
            d.op_class = CLASS_BYTE;
        end else begin
            d.op_class = CLASS_LITCTL;
        end
        d.uses_file = (d.op_class != CLASS_LITCTL);
        // The accumulator clear has no file operand; its free low bits must not
        // look like an indirect port, or they would change the cycle count.
        port_sel = (w[6:1] == 6'h00) && (w[13:7] != 7'h02);
        d.indirect_ref = (d.uses_file && port_sel) || ptr_move || ptr_indexed;
        if (d.uses_file && port_sel) begin
            d.ptr_num = w[0];
        end
        d.cond_skip = (w[13:10] == 4'h6) || (w[13:10] == 4'h7) ||
                      (w[13:8] == 6'h0b) || (w[13:8] == 6'h0f);
        d.skip_on_bit_set = w[10];
        d.dec_skip = (w[13:8] == 6'h0b);
        d.inc_skip = (w[13:8] == 6'h0f);
        // Calls, returns and jumps always change the program counter.
        d.always_two = (w[13:12] == 2'h2) || (w[13:9] == 5'h19) ||
                       (w[13:8] == 6'h34) ||
                       (w[13:2] == 12'h002) || (w[13:0] == 14'h000b);
    end
endmodule : field_split
`default_nettype wire

// ### logic/phase_gen.sv
/*
 * Four-phase generator splitting oscillator edges into instruction cycles.
 * Assumes a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module phase_gen (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Phase
    output logic [1:0] phase_out,
    output logic last_out
);
    import icd_pkg::*;
    typedef struct packed {
        logic [1:0] ph;
    } pg_state_t;
    pg_state_t s_r;
    pg_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ph = s_r.ph + 2'h1;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign phase_out = s_r.ph;
    assign last_out = (s_r.ph == PHASE_LAST);
endmodule : phase_gen
`default_nettype wire

// ### logic/instruction_cycle_decoder.sv
/*
 * Instruction cycle decoder: latches a word at the start of each instruction,
 * reports its fields and counts how many instruction cycles it holds.
 * Assumes program memory presents the next word when fetch_out is high and
 * the datapath supplies the bit, zero and pointer-region answers in time.
 */
// How it works
// - Each instruction is one 14-bit word with opcode and operands.
// - Opcodes sort into byte, bit and literal or control classes.
// - All other instructions finish in exactly one instruction cycle.
// - Direct and accumulator calls take two instruction cycles.
// - Returns of all three kinds take two instruction cycles.
// - Jumps and taken skips take two instruction cycles.
// - Second cycle of a two-cycle jump, call, return or taken skip runs as a no-operation.
// - Indirect access into program memory adds one instruction cycle.
// - One instruction cycle is four oscillator cycles.
// - Register operands follow read, modify, then write by destination.
// - The register is read even when only written.
// - The file address picks 0x00 to 0x7f of the bank.
// - Destination bit zero sends result to accumulator, one to register.
// - Bit number selects one bit of the eight-bit register.
// - Destination at bit 7, address bits 6:0, bit number bits 9:7.
// - Literal field is an immediate constant or target label.
// - Jumps and calls carry 11-bit targets; literals are 8-bit.
// - Don't-care bits never change the decode.
// - Pointer number selects one of two pointer registers.
// - Two-bit step field picks pre or post increment or decrement.
`timescale 1ns/10ps
`default_nettype none
module instruction_cycle_decoder (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Program memory
    input wire logic [13:0] word_in,
    output logic fetch_out,
    // Datapath answers
    input wire logic [7:0] file_data_in,
    input wire logic zero_result_in,
    input wire logic ptr0_prog_in,
    input wire logic ptr1_prog_in,
    // Decoded fields
    output icd_pkg::op_class_t op_class_out,
    output logic [6:0] file_addr_out,
    output logic dest_file_out,
    output logic [2:0] bit_num_out,
    output logic [7:0] lit8_out,
    output logic [10:0] lit11_out,
    output logic ptr_num_out,
    output icd_pkg::pointer_step_mode_t step_mode_out,
    output logic indirect_out,
    // Cycle control
    output logic [1:0] phase_out,
    output logic [1:0] cycles_out,
    output logic file_read_out,
    output logic result_write_out,
    output logic acc_write_out,
    output logic nop_cycle_out
);
    import icd_pkg::*;

    // ==========================================================
    // State
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_EXTRA,
        ST_FLUSH
    } seq_t;

    typedef struct packed {
        seq_t st;
        logic [13:0] word;
        logic [1:0] cycles;
        logic [1:0] left;
        logic fetch;
        logic rd;
        logic wr_file;
        logic wr_acc;
        logic nop;
        logic [1:0] ph;
    } dec_state_t;

    dec_state_t s_r;
    dec_state_t s_nxt;

    dec_if dif ();
    logic [1:0] ph;
    logic last;
    logic taken;
    logic prog_ptr;
    logic bit_val;
    logic [1:0] base_cyc;

    field_split u_split (
        .word_in(s_r.word),
        .d(dif.src)
    );

    phase_gen u_phase (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .phase_out(ph),
        .last_out(last)
    );

    // ==========================================================
    // Cycle count
    always_comb begin
        bit_val = file_data_in[dif.bit_num];
        taken = 1'b0;
        if (dif.dec_skip || dif.inc_skip) begin
            taken = zero_result_in;
        end else if (dif.cond_skip) begin
            taken = (bit_val == dif.skip_on_bit_set);
        end
        prog_ptr = dif.ptr_num ? ptr1_prog_in : ptr0_prog_in;
        base_cyc = (dif.always_two || taken) ? 2'h2 : 2'h1;
        if (dif.indirect_ref && prog_ptr) begin
            base_cyc = base_cyc + 2'h1;
        end
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.ph = ph;
        s_nxt.fetch = 1'b0;
        s_nxt.rd = 1'b0;
        s_nxt.wr_file = 1'b0;
        s_nxt.wr_acc = 1'b0;
        if (last) begin
            unique case (s_r.st)
                ST_EXEC: begin
                    s_nxt.cycles = base_cyc;
                    if (base_cyc == 2'h1) begin
                        s_nxt.fetch = 1'b1;
                        s_nxt.nop = 1'b0;
                    end else begin
                        s_nxt.left = base_cyc - 2'h1;
                        s_nxt.st = (dif.indirect_ref && base_cyc != 2'h1 &&
                                    !dif.always_two && !taken) ? ST_EXTRA : ST_FLUSH;
                        if (base_cyc == CYC_MAX) begin
                            s_nxt.st = ST_EXTRA;
                        end
                        s_nxt.nop = (s_nxt.st == ST_FLUSH);
                    end
                end
                ST_EXTRA: begin
                    s_nxt.left = s_r.left - 2'h1;
                    s_nxt.st = (s_r.left == 2'h1) ? ST_EXEC : ST_FLUSH;
                    s_nxt.nop = (s_nxt.st == ST_FLUSH);
                    s_nxt.fetch = (s_r.left == 2'h1);
                end
                ST_FLUSH: begin
                    s_nxt.left = s_r.left - 2'h1;
                    s_nxt.st = ST_EXEC;
                    s_nxt.nop = 1'b0;
                    s_nxt.fetch = 1'b1;
                end
                default: begin
                    s_nxt.st = ST_EXEC;
                end
            endcase
        end
        // A new word enters as the previous instruction cycle closes.
        if (s_r.fetch) begin
            s_nxt.word = word_in;
            s_nxt.st = ST_EXEC;
        end
        // Read, then write on the next clock, so the write has ended before a flushed cycle.
        if (s_r.st == ST_EXEC && !s_r.nop && dif.uses_file) begin
            s_nxt.rd = (ph == 2'h1);
            if (ph == 2'h2) begin
                s_nxt.wr_file = (dif.op_class == CLASS_BIT) || dif.dest_file;
                s_nxt.wr_acc = (dif.op_class == CLASS_BYTE) && !dif.dest_file;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
            s_r.fetch <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_class_out <= CLASS_LITCTL;
            file_addr_out <= '0;
            dest_file_out <= 1'b0;
            bit_num_out <= '0;
            lit8_out <= '0;
            lit11_out <= '0;
            ptr_num_out <= 1'b0;
            step_mode_out <= STEP_PRE_INC;
            indirect_out <= 1'b0;
        end else begin
            op_class_out <= dif.op_class;
            file_addr_out <= dif.file_addr & FILE_ADDR_MAX;
            dest_file_out <= dif.dest_file;
            bit_num_out <= dif.bit_num;
            lit8_out <= dif.lit8;
            lit11_out <= dif.lit11;
            ptr_num_out <= dif.ptr_num;
            step_mode_out <= dif.step_mode;
            indirect_out <= dif.indirect_ref;
        end
    end

    assign fetch_out = s_r.fetch;
    assign phase_out = s_r.ph;
    assign cycles_out = s_r.cycles;
    assign file_read_out = s_r.rd;
    assign result_write_out = s_r.wr_file;
    assign acc_write_out = s_r.wr_acc;
    assign nop_cycle_out = s_r.nop;

    // ==========================================================
    // Checks
    sequence seq_fetch_gap;
        fetch_out ##1 !fetch_out [*3];
    endsequence

    a_fetch_spacing: assert property (@(posedge clk_in) disable iff (rst_in)
        fetch_out |-> seq_fetch_gap)
        else $error("fetch closer than four clocks");
    a_phase_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
        phase_out == 2'h3 |=> phase_out == 2'h0)
        else $error("phase did not wrap");
    a_cycles_range: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(nop_cycle_out) |-> cycles_out != 2'h1)
        else $error("no-operation cycle on a one-cycle word");
    a_read_first: assert property (@(posedge clk_in) disable iff (rst_in)
        result_write_out |-> $past(file_read_out))
        else $error("write without earlier read");
    a_dest_excl: assert property (@(posedge clk_in) disable iff (rst_in)
        !(result_write_out && acc_write_out))
        else $error("both destinations written");
    a_nop_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        nop_cycle_out |-> !result_write_out && !acc_write_out)
        else $error("write during no-operation cycle");
    a_read_class: assert property (@(posedge clk_in) disable iff (rst_in)
        file_read_out |-> op_class_out != CLASS_LITCTL)
        else $error("register read for a word without file operand");
    a_nop_bounded: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(nop_cycle_out) |-> ##[1:12] fetch_out)
        else $error("no fetch after no-operation cycles");
endmodule : instruction_cycle_decoder
`default_nettype wire

// ### sim/prog_mem_model.sv
/*
 * Program memory and register file model that faces the decoder.
 * Assumes the bench offers one word per toggle of req_in, just after a clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module prog_mem_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Decoder side
    input wire logic fetch_in,
    input wire logic [6:0] file_addr_in,
    output logic [13:0] word_out,
    output logic [7:0] file_data_out,
    // Bench side
    input wire logic [13:0] next_word_in,
    input wire logic req_in,
    output logic ack_out
);
    logic [7:0] regs [0:127];
    logic [13:0] cur;
    // ==========================================================
    // Word lines
    // Outside a fetch the lines show the inverse, so a stray sample never looks right.
    assign cur = (req_in != ack_out) ? next_word_in : 14'h0000;
    assign word_out = fetch_in ? cur : ~cur;
    assign file_data_out = regs[file_addr_in];
    always @(posedge clk_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
        end else if (fetch_in) begin
            ack_out <= req_in;
        end
    end
endmodule : prog_mem_model
`default_nettype wire

// ### sim/tb_top.sv
/*
 * Self-checking bench for the instruction cycle decoder.
 * Assumes the program memory model and a 100 MHz core clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import icd_pkg::*;
    logic clk_in, rst_in, fetch_out, req, ack, zero_in, p0, p1;
    logic dest, pn, ind, rd, wf, wa, nop, c_d, c_pn, c_ind;
    logic [13:0] word_in, next_word;
    logic [7:0] file_data, lit8, c_l8;
    logic [6:0] fa, c_fa;
    logic [10:0] lit11, c_l11;
    logic [2:0] bn, c_bn;
    logic [1:0] phase, cycles, c_cls, c_sm, c_cyc;
    op_class_t cls;
    pointer_step_mode_t sm;
    int mismatches = 0;
    int check_count = 0;
    int n_rd = 0, n_wf = 0, n_wa = 0, n_nop = 0;
    int sp, d_rd, d_wf, d_wa, d_nop;

    instruction_cycle_decoder dut (.clk_in(clk_in), .rst_in(rst_in), .word_in(word_in),
        .fetch_out(fetch_out), .file_data_in(file_data), .zero_result_in(zero_in),
        .ptr0_prog_in(p0), .ptr1_prog_in(p1), .op_class_out(cls), .file_addr_out(fa),
        .dest_file_out(dest), .bit_num_out(bn), .lit8_out(lit8), .lit11_out(lit11),
        .ptr_num_out(pn), .step_mode_out(sm), .indirect_out(ind), .phase_out(phase),
        .cycles_out(cycles), .file_read_out(rd), .result_write_out(wf),
        .acc_write_out(wa), .nop_cycle_out(nop));
    prog_mem_model mem (.clk_in(clk_in), .rst_in(rst_in), .fetch_in(fetch_out),
        .file_addr_in(fa), .word_out(word_in), .file_data_out(file_data),
        .next_word_in(next_word), .req_in(req), .ack_out(ack));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (!rst_in) begin
            n_rd += int'(rd);
            n_wf += int'(wf);
            n_wa += int'(wa);
            n_nop += int'(nop);
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Offers one word and follows it until the fetch of the next one.
    task automatic exec(input logic [13:0] w, input bit cap);
        int k;
        logic [1:0] ph;
        next_word = w;
        req = ~req;
        k = 0;
        while (ack !== req && k < 20) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        check(16'(ack), 16'(req));
        for (k = 1; k < 16; k++) begin
            ph = phase + 2'h1;
            @(posedge clk_in);
            #1;
            check(16'(phase), 16'(ph));
            if (cap && k == 3) begin
                {c_cls, c_fa, c_d, c_bn, c_l8} = {cls, fa, dest, bn, lit8};
                {c_l11, c_pn, c_sm, c_ind} = {lit11, pn, sm, ind};
            end
            if (fetch_out === 1'b1) break;
        end
        if (cap) begin
            sp = k + 1;
            c_cyc = cycles;
        end
    endtask : exec

    // Two trailing no-operation words let every pulse of the word land in the counts.
    task automatic run(input logic [13:0] w);
        int r0, f0, a0, n0;
        {r0, f0, a0, n0} = {n_rd, n_wf, n_wa, n_nop};
        exec(w, 1'b1);
        exec(14'h0000, 1'b0);
        exec(14'h0000, 1'b0);
        {d_rd, d_wf, d_wa, d_nop} = {n_rd - r0, n_wf - f0, n_wa - a0, n_nop - n0};
    endtask : run

    task automatic expc(input logic [1:0] cyc);
        check(16'(sp), 16'(OSC_PER_ICYC * cyc));
        check(16'(c_cyc), 16'(cyc));
    endtask : expc

    function automatic logic [15:0] pl();
        return 16'({4'(d_rd), 4'(d_wf), 4'(d_wa)});
    endfunction : pl

    // ==========================================================
    // Scenarios
    task automatic t_byte();
        run(14'h07ff);
        check(16'(c_cls), 16'(CLASS_BYTE));
        check(16'({c_fa, c_d}), 16'h00ff);
        expc(2'h1);
        check(pl(), 16'h0110);
        run(14'h0725);
        check(16'({c_fa, c_d}), 16'h004a);
        check(pl(), 16'h0101);
        run(14'h00aa);
        check(pl(), 16'h0110);
        $display("test byte done");
    endtask : t_byte

    task automatic t_bit();
        for (int b = 0; b < 8; b++) begin
            run({4'h5, 3'(b), 7'h13});
            check(16'({c_cls, c_bn, c_fa}), 16'({2'(CLASS_BIT), 3'(b), 7'h13}));
        end
        $display("test bit done");
    endtask : t_bit

    task automatic t_skip();
        mem.regs[32] = 8'h04;
        run(14'h1d20);
        expc(2'h2);
        check(16'(d_nop), 16'h0004);
        run(14'h1920);
        expc(2'h1);
        mem.regs[32] = 8'h00;
        run(14'h1920);
        expc(2'h2);
        run(14'h1d20);
        expc(2'h1);
        zero_in = 1'b1;
        run(14'h0bb0);
        expc(2'h2);
        run(14'h0fb0);
        expc(2'h2);
        zero_in = 1'b0;
        run(14'h0fb0);
        expc(2'h1);
        $display("test skip done");
    endtask : t_skip

    task automatic t_ctl();
        logic [13:0] tbl [8] = '{14'h25a5, 14'h2ec3, 14'h32aa, 14'h000b,
            14'h000a, 14'h0009, 14'h0008, 14'h34c3};
        for (int i = 0; i < 8; i++) begin
            run(tbl[i]);
            check(16'(c_cls), 16'(CLASS_LITCTL));
            expc(2'h2);
            check(16'(d_nop), 16'h0004);
            if (i < 2) check(16'(c_l11), 16'(tbl[i][10:0]));
        end
        check(16'(c_l8), 16'h00c3);
        run(14'h3055);
        expc(2'h1);
        check(16'(c_l8), 16'h0055);
        $display("test control done");
    endtask : t_ctl

    task automatic t_dc();
        logic [15:0] a;
        logic [15:0] p;
        // A pointer into program memory would expose a false indirect decode.
        p0 = 1'b1;
        run(14'h0100);
        p = pl();
        a = {c_cls, c_cyc, p[11:0]};
        check(16'({c_cyc, c_ind}), 16'h0002);
        run(14'h0103);
        p = pl();
        check({c_cls, c_cyc, p[11:0]}, a);
        check(16'(c_ind), 16'h0000);
        p0 = 1'b0;
        $display("test dont care done");
    endtask : t_dc

    task automatic t_ind();
        for (int i = 0; i < 16; i++) begin
            run(14'h0010 | 14'(i));
            check(16'({c_pn, c_sm, c_ind}), 16'({i[2:0], 1'b1}));
            expc(2'h1);
        end
        p0 = 1'b1;
        run(14'h0010);
        expc(2'h2);
        run(14'h0014);
        expc(2'h1);
        run(14'h0700);
        expc(2'h2);
        p0 = 1'b0;
        p1 = 1'b1;
        zero_in = 1'b1;
        run(14'h0b81);
        expc(2'h3);
        check(16'(d_nop), 16'h0004);
        {p1, zero_in} = 2'h0;
        $display("test indirect done");
    endtask : t_ind

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {rst_in, req, zero_in, p0, p1} = 5'h10;
        next_word = 14'h0000;
        for (int i = 0; i < 128; i++) mem.regs[i] = 8'h00;
        repeat (8) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_byte();
        t_bit();
        t_skip();
        t_ctl();
        t_dc();
        t_ind();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
